// >>> dv/alu_ops_test.sv
// self-checking bench for the alu subset block over its register bus
`timescale 1ns/10ps
`default_nettype none
`include "alu_ops_map.svh"
module alu_ops_test
  import alu_ops_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        hsel_i    = 1'b0;
  logic [31:0] haddr_i   = 32'h0;
  logic [1:0]  htrans_i  = 2'h0;
  logic        hwrite_i  = 1'b0;
  logic [31:0] hwdata_i  = 32'h0;
  logic        wake_i    = 1'b0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        osc_run_o;
  logic [7:0]  port_a_direction_o;
  logic [7:0]  port_b_direction_o;
  logic [7:0]  port_c_direction_o;
  int          num_errors = 0;
  int          checks     = 0;
  int          cycles     = 0;
  logic [7:0]  ks [5] = '{8'h05, 8'h03, 8'h10, 8'hFF, 8'h06};
  logic [7:0]  ws [5] = '{8'h05, 8'h05, 8'h01, 8'h00, 8'h05};
  logic [10:0] e;

  alu_ops DUT (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .wake_i(wake_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .osc_run_o(osc_run_o),
    .port_a_direction_o(port_a_direction_o), .port_b_direction_o(port_b_direction_o),
    .port_c_direction_o(port_c_direction_o)
  );

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // ************************************************************
  // bus tasks and comparisons
  // ************************************************************
  // entered right after a rising edge; leaves at the edge ending the data phase
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    logic rdy;
    hsel_i   <= 1'b1;
    haddr_i  <= addr;
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    do begin
      @(posedge clk_sys_i);
      rdy = hreadyout_o;
    end while (rdy !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i   <= 1'b0;
    hwdata_i <= wdata;
    // read at the edge itself, before that edge's register updates land
    do begin
      @(posedge clk_sys_i);
      rdy   = hreadyout_o;
      rdata = hrdata_o;
    end while (rdy !== 1'b1);
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] d;
    bus(1'b1, addr, data, d);
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk(input string what, input logic [31:0] addr, input logic [31:0] exp,
                     input logic [31:0] mask);
    logic [31:0] d;
    bus(1'b0, addr, 32'h0, d);
    check(what, exp & mask, d & mask);
    check("hresp", 32'h0, {31'h0, hresp_o});
  endtask

  function automatic logic [31:0] fa(input int f);
    return {24'h0, `OFS_FILE} + 32'(f * 4);
  endfunction

  // one idle cycle after go so the next read sees the settled result
  task automatic exec(input opcode_e op, input logic dst, input logic [7:0] k,
                      input logic [6:0] f);
    wr({24'h0, `OFS_OPERAND}, {17'h0, f, k});
    wr({24'h0, `OFS_CTRL}, {23'h0, 1'b1, 3'h0, dst, op});
    @(posedge clk_sys_i);
  endtask

  // {result, z, dc, c}; carry means no borrow out
  function automatic logic [10:0] sub_exp(input logic [7:0] a, input logic [7:0] b,
                                          input logic bin);
    logic [8:0] full;
    logic [4:0] lo;
    full = {1'b0, a} - {1'b0, b} - {8'h0, bin};
    lo   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    return {full[7:0], full[7:0] == 8'h00, ~lo[4], ~full[8]};
  endfunction

  task automatic conclude();
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    check("dir_a", 32'hFF, {24'h0, port_a_direction_o});
    check("osc_run", 32'h1, {31'h0, osc_run_o});
    chk("status", {24'h0, `OFS_STATUS}, 32'h18, 32'h7F);
    for (int i = 0; i < 5; i++) begin
      wr({24'h0, `OFS_ACC}, {24'h0, ws[i]});
      wr({24'h0, `OFS_STATUS}, 32'h0);
      exec(OP_LITERAL_MINUS_ACC, 1'b0, ks[i], 7'h0);
      e = sub_exp(ks[i], ws[i], 1'b0);
      chk("lit_acc", {24'h0, `OFS_ACC}, {24'h0, e[10:3]}, 32'hFF);
      chk("lit_st", {24'h0, `OFS_STATUS}, {29'h3, e[2:0]}, 32'h7F);
      wr(fa(3), {24'h0, ks[i]});
      // the literal result sits in acc; restore the operand and clear flags
      wr({24'h0, `OFS_ACC}, {24'h0, ws[i]});
      wr({24'h0, `OFS_STATUS}, 32'h0);
      exec(OP_FILE_MINUS_ACC, 1'b0, 8'h0, 7'd3);
      chk("file_acc", {24'h0, `OFS_ACC}, {24'h0, e[10:3]}, 32'hFF);
      chk("file_st", {24'h0, `OFS_STATUS}, {29'h3, e[2:0]}, 32'h7F);
      chk("file_kept", fa(3), {24'h0, ks[i]}, 32'hFF);
      wr({24'h0, `OFS_ACC}, {24'h0, ws[i]});
      wr({24'h0, `OFS_STATUS}, {31'h0, i[0]});
      exec(OP_FILE_MINUS_ACC_WITH_BORROW, 1'b1, 8'h0, 7'd3);
      e = sub_exp(ks[i], ws[i], ~i[0]);
      chk("brw_file", fa(3), {24'h0, e[10:3]}, 32'hFF);
      chk("brw_st", {24'h0, `OFS_STATUS}, {29'h3, e[2:0]}, 32'h7F);
      chk("brw_acc", {24'h0, `OFS_ACC}, {24'h0, ws[i]}, 32'hFF);
    end
    wr({24'h0, `OFS_STATUS}, 32'h5);
    wr(fa(5), 32'h3C);
    exec(OP_NIBBLE_EXCHANGE, 1'b1, 8'h0, 7'd5);
    chk("swap_file", fa(5), 32'hC3, 32'hFF);
    exec(OP_NIBBLE_EXCHANGE, 1'b0, 8'h0, 7'd5);
    chk("swap_acc", {24'h0, `OFS_ACC}, 32'h3C, 32'hFF);
    chk("swap_st", {24'h0, `OFS_STATUS}, 32'h1D, 32'h7F);
    wr({24'h0, `OFS_STATUS}, 32'h3);
    wr({24'h0, `OFS_ACC}, 32'h5A);
    exec(OP_LITERAL_EXCLUSIVE_OR, 1'b0, 8'h5A, 7'h0);
    chk("lxor_acc", {24'h0, `OFS_ACC}, 32'h00, 32'hFF);
    chk("lxor_st", {24'h0, `OFS_STATUS}, 32'h1F, 32'h7F);
    exec(OP_LITERAL_EXCLUSIVE_OR, 1'b0, 8'hFF, 7'h0);
    chk("lxor_st2", {24'h0, `OFS_STATUS}, 32'h1B, 32'h7F);
    wr(fa(7), 32'h0F);
    exec(OP_FILE_EXCLUSIVE_OR, 1'b1, 8'h0, 7'd7);
    chk("fxor_file", fa(7), 32'hF0, 32'hFF);
    chk("fxor_acc", {24'h0, `OFS_ACC}, 32'hFF, 32'hFF);
    wr(fa(31), 32'hFF);
    exec(OP_FILE_EXCLUSIVE_OR, 1'b0, 8'h0, 7'd31);
    chk("fxor_acc2", {24'h0, `OFS_ACC}, 32'h00, 32'hFF);
    chk("fxor_st", {24'h0, `OFS_STATUS}, 32'h1F, 32'h7F);
    for (int s = 5; s < 8; s++) begin
      wr({24'h0, `OFS_ACC}, 32'(8'h11 * s));
      exec(OP_PIN_DIRECTION_LOAD, 1'b0, 8'h0, 7'(s));
    end
    check("dir_a", 32'h55, {24'h0, port_a_direction_o});
    check("dir_b", 32'h66, {24'h0, port_b_direction_o});
    check("dir_c", 32'h77, {24'h0, port_c_direction_o});
    chk("dir_b_reg", {24'h0, `OFS_DIR_B}, 32'h66, 32'hFF);
    chk("dir_st", {24'h0, `OFS_STATUS}, 32'h1F, 32'h7F);
    wr({24'h0, `OFS_ACC}, 32'h0);
    exec(OP_PIN_DIRECTION_LOAD, 1'b0, 8'h0, 7'd4);
    check("dir_kept", 32'h55, {24'h0, port_a_direction_o});
    chk("dir_err", {24'h0, `OFS_STATUS}, 32'h5F, 32'h7F);
    wr(32'h20, 32'hFFFF);
    chk("unmapped", 32'h20, 32'h0, 32'hFFFFFFFF);
    wr({24'h0, `OFS_STATUS}, 32'h2);
    exec(OP_SLEEP, 1'b0, 8'h0, 7'h0);
    check("osc_stop", 32'h0, {31'h0, osc_run_o});
    chk("sleep_st", {24'h0, `OFS_STATUS}, 32'h32, 32'h7F);
    chk("wdog", {24'h0, `OFS_WDOG}, 32'h0, 32'hFFFF);
    exec(OP_LITERAL_EXCLUSIVE_OR, 1'b0, 8'hFF, 7'h0);
    chk("asleep_acc", {24'h0, `OFS_ACC}, 32'h0, 32'hFF);
    wake_i <= 1'b1;
    for (int n = 0; n < 20 && osc_run_o !== 1'b1; n++) @(posedge clk_sys_i);
    wake_i <= 1'b0;
    check("osc_wake", 32'h1, {31'h0, osc_run_o});
    exec(OP_LITERAL_EXCLUSIVE_OR, 1'b0, 8'hED, 7'h0);
    chk("wake_acc", {24'h0, `OFS_ACC}, 32'hED, 32'hFF);
    conclude();
  end
endmodule // alu_ops_test
`default_nettype wire

// >>> verilog/alu_ops.sv
// alu subset: subtract, nibble exchange, exclusive or, direction load, sleep
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "alu_ops_map.svh"
module alu_ops
  import alu_ops_pkg::*;
#(
  parameter int FILE_DEPTH = `FILE_WORDS
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic        wake_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             osc_run_o,
  output logic      [7:0]  port_a_direction_o,
  output logic      [7:0]  port_b_direction_o,
  output logic      [7:0]  port_c_direction_o
);
  // ****************************************
  // bus address phase capture
  // ****************************************
  logic        wr_pend_r, wr_pend_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic        take;

  // ****************************************
  // datapath state
  // ****************************************
  logic [7:0]  file_mem [FILE_DEPTH];
  logic [7:0]  acc_r, acc_nxt;
  logic [7:0]  operand_k_r, operand_k_nxt;
  logic [6:0]  operand_f_r, operand_f_nxt;
  logic [3:0]  op_r, op_nxt;
  logic        dst_r, dst_nxt;
  logic        c_r, c_nxt, dc_r, dc_nxt, z_r, z_nxt;
  logic        pd_r, pd_nxt, to_r, to_nxt, err_r, err_nxt;
  logic [7:0]  dir_a_r, dir_a_nxt, dir_b_r, dir_b_nxt, dir_c_r, dir_c_nxt;
  logic [7:0]  wdog_r, wdog_nxt, presc_r, presc_nxt;
  core_state_e state_r, state_nxt;
  logic        wake_s1_r, wake_s2_r;
  logic        go;
  logic        file_we;
  logic [6:0]  file_wa;
  logic [7:0]  file_wd;
  logic [7:0]  fval;
  logic [8:0]  diff;
  logic [4:0]  ndiff;
  logic [7:0]  res;
  logic [7:0]  sub_a;
  logic        sub_bin;
  logic        is_file_reg;

  assign take = hsel_i & hready_i & htrans_i[1];
  assign is_file_reg = (addr_r >= `OFS_FILE);
  assign go = wr_pend_r & (addr_r == `OFS_CTRL) & hwdata_i[`CTRL_GO_BIT]
              & (state_r == ST_RUN);
  assign fval = file_mem[operand_f_r];

  // ****************************************
  // bus next state
  // ****************************************
  always_comb begin
    wr_pend_nxt = take & hwrite_i;
    addr_nxt    = take ? haddr_i[7:0] : addr_r;
    hrdata_nxt  = 32'h0000_0000;
    if (take & ~hwrite_i) begin
      if (haddr_i[7:0] >= `OFS_FILE) begin
        hrdata_nxt = {24'h00_0000, file_mem[haddr_i[8:2] - 7'h20]};
      end else if (haddr_i[7:0] == `OFS_CTRL) begin
        hrdata_nxt = {27'h000_0000, dst_r, op_r};
      end else if (haddr_i[7:0] == `OFS_OPERAND) begin
        hrdata_nxt = {17'h0_0000, operand_f_r, operand_k_r};
      end else if (haddr_i[7:0] == `OFS_ACC) begin
        hrdata_nxt = {24'h00_0000, acc_r};
      end else if (haddr_i[7:0] == `OFS_STATUS) begin
        hrdata_nxt = {25'h000_0000, err_r, state_r == ST_ASLEEP, to_r, pd_r, z_r, dc_r, c_r};
      end else if (haddr_i[7:0] == `OFS_DIR_A) begin
        hrdata_nxt = {24'h00_0000, dir_a_r};
      end else if (haddr_i[7:0] == `OFS_DIR_B) begin
        hrdata_nxt = {24'h00_0000, dir_b_r};
      end else if (haddr_i[7:0] == `OFS_DIR_C) begin
        hrdata_nxt = {24'h00_0000, dir_c_r};
      end else if (haddr_i[7:0] == `OFS_WDOG) begin
        hrdata_nxt = {16'h0000, presc_r, wdog_r};
      end
    end
  end

  // ****************************************
  // execution next state
  // ****************************************
  always_comb begin
    op_nxt        = op_r;
    dst_nxt       = dst_r;
    operand_k_nxt = operand_k_r;
    operand_f_nxt = operand_f_r;
    acc_nxt       = acc_r;
    c_nxt  = c_r;
    dc_nxt = dc_r;
    z_nxt  = z_r;
    pd_nxt = pd_r;
    to_nxt = to_r;
    err_nxt = err_r;
    dir_a_nxt = dir_a_r;
    dir_b_nxt = dir_b_r;
    dir_c_nxt = dir_c_r;
    wdog_nxt  = wdog_r + 8'h01;
    presc_nxt = presc_r;
    state_nxt = state_r;
    file_we = 1'b0;
    file_wa = operand_f_r;
    file_wd = 8'h00;
    // borrowed subtract shares one adder; inverted carry is the borrow in
    sub_a   = (op_r == OP_LITERAL_MINUS_ACC) ? operand_k_r : fval;
    sub_bin = (op_r == OP_FILE_MINUS_ACC_WITH_BORROW) ? ~c_r : 1'b0;
    diff  = {1'b0, sub_a} - {1'b0, acc_r} - {8'h00, sub_bin};
    ndiff = {1'b0, sub_a[3:0]} - {1'b0, acc_r[3:0]} - {4'h0, sub_bin};
    res   = diff[7:0];
    if (wr_pend_r & (addr_r == `OFS_CTRL) & (state_r == ST_RUN)) begin
      op_nxt  = hwdata_i[`CTRL_OP_LSB +: 4];
      dst_nxt = hwdata_i[`CTRL_DST_BIT];
    end
    if (wr_pend_r & (addr_r == `OFS_OPERAND)) begin
      operand_k_nxt = hwdata_i[`OPND_K_LSB +: 8];
      operand_f_nxt = hwdata_i[`OPND_F_LSB +: 7];
    end
    if (wr_pend_r & (addr_r == `OFS_ACC)) begin
      acc_nxt = hwdata_i[7:0];
    end
    if (wr_pend_r & (addr_r == `OFS_STATUS)) begin
      c_nxt  = hwdata_i[`ST_C];
      dc_nxt = hwdata_i[`ST_DC];
      z_nxt  = hwdata_i[`ST_Z];
      err_nxt = 1'b0;
    end
    if (wr_pend_r & is_file_reg) begin
      file_we = 1'b1;
      file_wa = 7'(addr_r[7:2] - 6'h20);
      file_wd = hwdata_i[7:0];
    end
    if (go) begin
      // every operation finishes in this one cycle
      case (hwdata_i[`CTRL_OP_LSB +: 4])
        OP_LITERAL_MINUS_ACC: begin
          diff  = {1'b0, operand_k_r} - {1'b0, acc_r};
          ndiff = {1'b0, operand_k_r[3:0]} - {1'b0, acc_r[3:0]};
          acc_nxt = diff[7:0];
          c_nxt   = ~diff[8];
          dc_nxt  = ~ndiff[4];
          z_nxt   = (diff[7:0] == 8'h00);
        end
        OP_FILE_MINUS_ACC, OP_FILE_MINUS_ACC_WITH_BORROW: begin
          sub_bin = (hwdata_i[`CTRL_OP_LSB +: 4] == OP_FILE_MINUS_ACC_WITH_BORROW)
                    ? ~c_r : 1'b0;
          diff  = {1'b0, fval} - {1'b0, acc_r} - {8'h00, sub_bin};
          ndiff = {1'b0, fval[3:0]} - {1'b0, acc_r[3:0]} - {4'h0, sub_bin};
          res   = diff[7:0];
          c_nxt  = ~diff[8];
          dc_nxt = ~ndiff[4];
          z_nxt  = (res == 8'h00);
        end
        OP_NIBBLE_EXCHANGE: begin
          res = {fval[3:0], fval[7:4]};
        end
        OP_LITERAL_EXCLUSIVE_OR: begin
          acc_nxt = acc_r ^ operand_k_r;
          z_nxt   = ((acc_r ^ operand_k_r) == 8'h00);
        end
        OP_FILE_EXCLUSIVE_OR: begin
          res   = acc_r ^ fval;
          z_nxt = (res == 8'h00);
        end
        OP_PIN_DIRECTION_LOAD: begin
          if (operand_f_r == `DIR_SEL_A) begin
            dir_a_nxt = acc_r;
          end else if (operand_f_r == `DIR_SEL_B) begin
            dir_b_nxt = acc_r;
          end else if (operand_f_r == `DIR_SEL_C) begin
            dir_c_nxt = acc_r;
          end else begin
            err_nxt = 1'b1;
          end
        end
        OP_SLEEP: begin
          // arithmetic flags are left alone here
          wdog_nxt  = `WDOG_CLEAR;
          presc_nxt = `PRESC_CLEAR;
          pd_nxt    = 1'b0;
          to_nxt    = 1'b1;
          state_nxt = ST_ASLEEP;
        end
        default: begin
          err_nxt = 1'b1;
        end
      endcase
      case (hwdata_i[`CTRL_OP_LSB +: 4])
        OP_FILE_MINUS_ACC, OP_FILE_MINUS_ACC_WITH_BORROW,
        OP_NIBBLE_EXCHANGE, OP_FILE_EXCLUSIVE_OR: begin
          if (hwdata_i[`CTRL_DST_BIT]) begin
            file_we = 1'b1;
            file_wa = operand_f_r;
            file_wd = res;
          end else begin
            acc_nxt = res;
          end
        end
        default: begin
        end
      endcase
    end
    // stopped oscillator freezes the watchdog; only the wake pin or reset restarts it
    if (state_r == ST_ASLEEP) begin
      wdog_nxt = wdog_r;
      if (wake_s2_r) begin
        state_nxt = ST_RUN;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
      acc_r     <= 8'h00;
      operand_k_r <= 8'h00;
      operand_f_r <= 7'h00;
      op_r  <= 4'h0;
      dst_r <= 1'b0;
      c_r   <= 1'b0;
      dc_r  <= 1'b0;
      z_r   <= 1'b0;
      pd_r  <= 1'b1;
      to_r  <= 1'b1;
      err_r <= 1'b0;
      dir_a_r <= `DIR_RESET;
      dir_b_r <= `DIR_RESET;
      dir_c_r <= `DIR_RESET;
      wdog_r  <= 8'h00;
      presc_r <= 8'h00;
      state_r <= ST_RUN;
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      addr_r    <= addr_nxt;
      hrdata_r  <= hrdata_nxt;
      acc_r     <= acc_nxt;
      operand_k_r <= operand_k_nxt;
      operand_f_r <= operand_f_nxt;
      op_r  <= op_nxt;
      dst_r <= dst_nxt;
      c_r   <= c_nxt;
      dc_r  <= dc_nxt;
      z_r   <= z_nxt;
      pd_r  <= pd_nxt;
      to_r  <= to_nxt;
      err_r <= err_nxt;
      dir_a_r <= dir_a_nxt;
      dir_b_r <= dir_b_nxt;
      dir_c_r <= dir_c_nxt;
      wdog_r  <= wdog_nxt;
      presc_r <= presc_nxt;
      state_r <= state_nxt;
      wake_s1_r <= wake_i;
      wake_s2_r <= wake_s1_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
  end

  assign hrdata_o           = hrdata_r;
  assign hreadyout_o        = 1'b1;
  assign hresp_o            = 1'b0;
  assign osc_run_o          = (state_r == ST_RUN);
  assign port_a_direction_o = dir_a_r;
  assign port_b_direction_o = dir_b_r;
  assign port_c_direction_o = dir_c_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence go_op(logic [3:0] o);
    go && hwdata_i[3:0] == o;
  endsequence

  lit_sub_carry_a: assert property (go_op(OP_LITERAL_MINUS_ACC) |=>
    acc_r == 8'($past(operand_k_r) - $past(acc_r))
    && c_r == ($past(acc_r) <= $past(operand_k_r)))
    else $error("literal subtract carry wrong");
  lit_sub_dc_a: assert property (go_op(OP_LITERAL_MINUS_ACC) |=>
    dc_r == ($past(acc_r[3:0]) <= $past(operand_k_r[3:0])))
    else $error("literal subtract half borrow wrong");
  sleep_flags_a: assert property (go_op(OP_SLEEP) |=>
    !pd_r && to_r && wdog_r == 8'h00 && presc_r == 8'h00)
    else $error("sleep flags wrong");
  sleep_arith_a: assert property (go_op(OP_SLEEP) |=>
    $stable(c_r) && $stable(dc_r) && $stable(z_r))
    else $error("sleep touched arithmetic flags");
  sleep_stop_a: assert property (go_op(OP_SLEEP) |=> !osc_run_o)
    else $error("oscillator not stopped");
  file_sub_c_a: assert property (go_op(OP_FILE_MINUS_ACC) |=>
    c_r == ($past(acc_r) <= $past(fval)))
    else $error("file subtract carry wrong");
  swap_flags_a: assert property (go_op(OP_NIBBLE_EXCHANGE) |=>
    $stable(c_r) && $stable(dc_r) && $stable(z_r))
    else $error("swap changed flags");
  lit_xor_a: assert property (go_op(OP_LITERAL_EXCLUSIVE_OR) |=>
    acc_r == ($past(acc_r) ^ $past(operand_k_r)) && z_r == (acc_r == 8'h00))
    else $error("literal xor wrong");
  dir_load_a: assert property (go_op(OP_PIN_DIRECTION_LOAD) && operand_f_r == 7'h06
    |=> port_b_direction_o == $past(acc_r))
    else $error("direction load wrong");
endmodule // alu_ops
`default_nettype wire

// >>> verilog/alu_ops_map.svh
// register offsets, field positions and reset values for the alu subset block
`ifndef ALU_OPS_MAP_SVH
`define ALU_OPS_MAP_SVH
`define OFS_CTRL     8'h00
`define OFS_OPERAND  8'h04
`define OFS_ACC      8'h08
`define OFS_STATUS   8'h0C
`define OFS_DIR_A    8'h10
`define OFS_DIR_B    8'h14
`define OFS_DIR_C    8'h18
`define OFS_WDOG     8'h1C
`define OFS_FILE     8'h80
`define FILE_WORDS   128
`define CTRL_OP_LSB  0
`define CTRL_DST_BIT 4
`define CTRL_GO_BIT  8
`define OPND_K_LSB   0
`define OPND_F_LSB   8
`define ST_C         0
`define ST_DC        1
`define ST_Z         2
`define ST_PD        3
`define ST_TO        4
`define ST_SLEEP     5
`define ST_ERR       6
`define DIR_RESET    8'hFF
`define ST_RESET     5'h18
`define DIR_SEL_A    7'h05
`define DIR_SEL_B    7'h06
`define DIR_SEL_C    7'h07
`define WDOG_CLEAR   8'h00
`define PRESC_CLEAR  8'h00
`endif

// >>> verilog/alu_ops_pkg.sv
// types shared by the alu subset block
`default_nettype none
package alu_ops_pkg;
  typedef enum logic [3:0] {
    OP_LITERAL_MINUS_ACC          = 4'h0,
    OP_FILE_MINUS_ACC             = 4'h1,
    OP_FILE_MINUS_ACC_WITH_BORROW = 4'h2,
    OP_NIBBLE_EXCHANGE            = 4'h3,
    OP_LITERAL_EXCLUSIVE_OR       = 4'h4,
    OP_FILE_EXCLUSIVE_OR          = 4'h5,
    OP_PIN_DIRECTION_LOAD         = 4'h6,
    OP_SLEEP                      = 4'h7
  } opcode_e;
  typedef enum {ST_RUN, ST_ASLEEP} core_state_e;
endpackage
`default_nettype wire
